// file: design/stfc_pkg.sv
// Package for the transmit frame configuration block.
// Assumes a single 250 MHz core clock and a plain single-word register port.
package stfc_pkg;

    // ************************************************************
    // Register port
    // ************************************************************
    localparam int unsigned ADDR_W      = 4;
    localparam logic [3:0]  CTRL_OFFSET = 4'h0;
    localparam logic [3:0]  STAT_OFFSET = 4'h4;
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK  = 32'hFFFF_7FF0;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int unsigned PHASE_BIT   = 31;
    localparam int unsigned FRLEN2_LSB  = 24;
    localparam int unsigned WDLEN2_LSB  = 21;
    localparam int unsigned COMPAND_LSB = 19;
    localparam int unsigned FIG_BIT     = 18;
    localparam int unsigned DATDLY_LSB  = 16;
    localparam int unsigned FRLEN1_LSB  = 8;
    localparam int unsigned WDLEN1_LSB  = 5;
    localparam int unsigned REV_BIT     = 4;

    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int unsigned ST_ACTIVE_BIT   = 0;
    localparam int unsigned ST_PHASE2_BIT   = 1;
    localparam int unsigned ST_WORDCNT_LSB  = 2;
    localparam int unsigned ST_UNDERRUN_BIT = 9;

    // ************************************************************
    // Field codes
    // ************************************************************
    localparam logic [2:0] WL_8  = 3'h0;
    localparam logic [2:0] WL_12 = 3'h1;
    localparam logic [2:0] WL_16 = 3'h2;
    localparam logic [2:0] WL_20 = 3'h3;
    localparam logic [2:0] WL_24 = 3'h4;
    localparam logic [2:0] WL_32 = 3'h5;
    localparam logic [1:0] CMP_NONE = 2'h0;
    localparam logic [1:0] CMP_LSB  = 2'h1;
    localparam logic [1:0] CMP_MU   = 2'h2;
    localparam logic [1:0] CMP_A    = 2'h3;
    localparam logic [1:0] DLY_RSVD = 2'h3;
    localparam logic [1:0] DLY_MAX  = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DELAY = 3'b010,
        ST_SHIFT = 3'b100
    } stfc_state_e;

endpackage

// file: design/stfc_tx_frame_cfg.sv
// Transmit frame control register and the frame sequencer it steers.
// Assumes one bit period per core clock, an unsynchronised frame-sync pin,
// and a word source on the same clock.
//
// Behaviour
// - Phase-two length is the field at bits 30-24 plus one, 1 to 128 words.
// - Phase-one length is the field at bits 14-8 plus one, 1 to 128 words.
// - Phase-two word length code at bits 23-21 means 8,12,16,20,24,32 bits; 6 and 7 reserved.
// - Phase-one word length code at bits 7-5 uses the same mapping.
// - Companding code at bits 20-19: 0 plain, 2 mu-law, 3 A-law.
// - Nonzero companding only applies when the word length code is 8 bits.
// - Companding code 1 sends 8-bit words uncompanded, least significant bit first.
// - With bit 18 clear, every later frame sync restarts the transfer.
// - With bit 18 set, later frame syncs are ignored and the frame continues.
// - The first data bit follows frame sync by 0, 1 or 2 bit periods per bits 17-16.
// - Bit 15 and bits 3-0 read as zero and ignore writes.
// - Bit 4 set sends 32-bit words least significant bit first.
`timescale 1ns/10ps
module stfc_tx_frame_cfg (
    input  wire logic                        clock,     // Core clock, 250 MHz
    input  wire logic                        rstn,      // Async reset, active low
    input  wire logic [stfc_pkg::ADDR_W-1:0] reg_addr,  // Register byte address
    input  wire logic [31:0]                 reg_wdata, // Write data
    input  wire logic                        reg_wr,    // Write strobe
    input  wire logic                        reg_rd,    // Read strobe
    output logic      [31:0]                 reg_rdata, // Read data, cycle after strobe
    input  wire logic                        tx_sync_pin, // Frame sync from pin
    input  wire logic [31:0]                 tx_word,   // Next word to send
    input  wire logic                        tx_valid,  // Word available
    output logic                             tx_ready,  // Word taken this cycle
    output logic                             tx_data,   // Serial data bit
    output logic                             tx_active  // Data bit is being driven
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [31:0]           ctrl;
        logic [31:0]           rdata;
        logic                  sync_meta;
        logic                  sync_q;
        logic                  sync_prev;
        stfc_pkg::stfc_state_e state;
        logic                  phase2;
        logic [6:0]            word_cnt;
        logic [5:0]            bit_cnt;
        logic [1:0]            dly_cnt;
        logic [31:0]           shift;
        logic                  underrun;
    } stfc_regs_s;

    stfc_regs_s q;
    stfc_regs_s d;

    // ************************************************************
    // Control fields
    // ************************************************************
    logic       dual;
    logic [6:0] len1;
    logic [6:0] len2;
    logic [2:0] bits1;
    logic [2:0] bits2;
    logic [1:0] cmp;
    logic       fig;
    logic [1:0] dly;
    logic       rev;

    assign dual  = q.ctrl[stfc_pkg::PHASE_BIT];
    assign len2  = q.ctrl[stfc_pkg::FRLEN2_LSB +: 7];
    assign bits2 = q.ctrl[stfc_pkg::WDLEN2_LSB +: 3];
    assign cmp   = q.ctrl[stfc_pkg::COMPAND_LSB +: 2];
    assign fig   = q.ctrl[stfc_pkg::FIG_BIT];
    assign dly   = q.ctrl[stfc_pkg::DATDLY_LSB +: 2];
    assign len1  = q.ctrl[stfc_pkg::FRLEN1_LSB +: 7];
    assign bits1 = q.ctrl[stfc_pkg::WDLEN1_LSB +: 3];
    assign rev   = q.ctrl[stfc_pkg::REV_BIT];

    // ************************************************************
    // Sequencing terms
    // ************************************************************
    logic        fs_rise;
    logic        word_end;
    logic        phase_last;
    logic        frame_end;
    logic        restart;
    logic        load;
    logic        load_ph2;
    logic [31:0] fmt_word;
    logic [5:0]  fmt_last;
    logic [31:0] status;

    assign fs_rise    = q.sync_q & ~q.sync_prev;
    assign word_end   = (q.state == stfc_pkg::ST_SHIFT) && (q.bit_cnt == 6'h00);
    assign phase_last = q.word_cnt == (q.phase2 ? len2 : len1);
    assign frame_end  = word_end && phase_last && (q.phase2 || !dual);
    // A sync outside a frame always starts one; inside, only when not ignored
    assign restart    = fs_rise && ((q.state == stfc_pkg::ST_IDLE) || !fig);
    assign load       = !restart && (((q.state == stfc_pkg::ST_DELAY) && (q.dly_cnt == 2'h0))
                        || (word_end && !frame_end));
    assign load_ph2   = (word_end && phase_last) ? 1'b1 : q.phase2;

    assign tx_ready  = load;
    assign tx_data   = q.shift[31];
    assign tx_active = q.state == stfc_pkg::ST_SHIFT;
    assign reg_rdata = q.rdata;

    assign status = {22'h00_0000, q.underrun, q.word_cnt, q.phase2, tx_active};

    stfc_word_fmt u_fmt (
        .word       (tx_valid ? tx_word : 32'h0000_0000),
        .bits_code  (load_ph2 ? bits2 : bits1),
        .compand    (cmp),
        .reverse    (rev),
        .shift_word (fmt_word),
        .last_bit   (fmt_last)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        d = q;
        d.sync_meta = tx_sync_pin;
        d.sync_q    = q.sync_meta;
        d.sync_prev = q.sync_q;
        d.rdata     = 32'h0000_0000;
        if (reg_wr && reg_addr == stfc_pkg::CTRL_OFFSET) begin
            d.ctrl = reg_wdata & stfc_pkg::CTRL_WMASK;
        end
        if (reg_wr && reg_addr == stfc_pkg::STAT_OFFSET
            && reg_wdata[stfc_pkg::ST_UNDERRUN_BIT]) begin
            d.underrun = 1'b0;
        end
        if (reg_rd) begin
            case (reg_addr)
                stfc_pkg::CTRL_OFFSET: d.rdata = q.ctrl;
                stfc_pkg::STAT_OFFSET: d.rdata = status;
                default:               d.rdata = 32'h0000_0000;
            endcase
        end
        if (restart) begin
            d.state    = stfc_pkg::ST_DELAY;
            d.phase2   = 1'b0;
            d.word_cnt = 7'h00;
            // Reserved delay code is clamped to the longest legal delay
            d.dly_cnt  = (dly == stfc_pkg::DLY_RSVD) ? stfc_pkg::DLY_MAX : dly;
        end else begin
            case (q.state)
                stfc_pkg::ST_IDLE: begin
                    d.state = stfc_pkg::ST_IDLE;
                end
                stfc_pkg::ST_DELAY: begin
                    if (q.dly_cnt != 2'h0) begin
                        d.dly_cnt = q.dly_cnt - 2'h1;
                    end
                end
                stfc_pkg::ST_SHIFT: begin
                    d.shift   = {q.shift[30:0], 1'b0};
                    d.bit_cnt = q.bit_cnt - 6'h01;
                    if (frame_end) begin
                        d.state = stfc_pkg::ST_IDLE;
                    end else if (word_end) begin
                        if (phase_last) begin
                            d.phase2   = 1'b1;
                            d.word_cnt = 7'h00;
                        end else begin
                            d.word_cnt = q.word_cnt + 7'h01;
                        end
                    end
                end
                default: begin
                    d.state = stfc_pkg::ST_IDLE;
                end
            endcase
        end
        if (load) begin
            d.state   = stfc_pkg::ST_SHIFT;
            d.shift   = fmt_word;
            d.bit_cnt = fmt_last;
            // Set after the clear so a same-cycle underrun is never lost
            if (!tx_valid) begin
                d.underrun = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q       <= '0;
            q.ctrl  <= stfc_pkg::CTRL_RESET;
            q.state <= stfc_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    logic plain_load;
    assign plain_load = load && tx_valid && (cmp == stfc_pkg::CMP_NONE) && !rev;

    // Reversed copy of the low byte, for the LSB-first byte check
    logic [7:0] low_byte_rev;
    assign low_byte_rev = {tx_word[0], tx_word[1], tx_word[2], tx_word[3],
                           tx_word[4], tx_word[5], tx_word[6], tx_word[7]};

    sequence s_quiet2;
        !fs_rise [*2];
    endsequence

    sequence s_quiet3;
        !fs_rise [*3];
    endsequence

    // First data bit follows one quiet cycle
    sequence s_start;
        !tx_active ##1 tx_active;
    endsequence

    AST_RSVD_READ_ZERO: assert property (reg_rd && reg_addr == stfc_pkg::CTRL_OFFSET
        |=> reg_rdata[15] == 1'b0 && reg_rdata[3:0] == 4'h0)
        else $error("Reserved control bits read nonzero");

    AST_CTRL_READBACK: assert property (reg_rd && reg_addr == stfc_pkg::CTRL_OFFSET
        |=> reg_rdata == $past(q.ctrl))
        else $error("Control readback mismatch");

    AST_DELAY_ONE: assert property (q.state == stfc_pkg::ST_IDLE && fs_rise
        && dly == 2'h1 && !reg_wr ##1 s_quiet2 |-> ##0 s_start)
        else $error("One-bit delay frame did not start on time");

    AST_DELAY_RSVD: assert property (q.state == stfc_pkg::ST_IDLE && fs_rise
        && dly == stfc_pkg::DLY_RSVD && !reg_wr ##1 s_quiet3 |-> ##0 s_start)
        else $error("Reserved delay code not held to two bits");

    AST_SYNC_START: assert property (q.state == stfc_pkg::ST_IDLE && fs_rise
        |=> q.state == stfc_pkg::ST_DELAY && q.word_cnt == 7'h00 && !q.phase2)
        else $error("Frame sync did not start a frame");

    AST_RSVD_WRITE: assert property (reg_wr && reg_addr == stfc_pkg::CTRL_OFFSET
        |=> q.ctrl[15] == 1'b0 && q.ctrl[3:0] == 4'h0)
        else $error("Reserved control bits took a write");

    AST_DELAY_ZERO: assert property (q.state == stfc_pkg::ST_IDLE && fs_rise
        && dly == 2'h0 && !reg_wr |=> !tx_active ##1 (tx_active || fs_rise))
        else $error("Zero delay frame did not start on time");

    AST_DELAY_TWO_START: assert property (q.state == stfc_pkg::ST_IDLE && fs_rise
        && dly == 2'h2 && !reg_wr ##1 s_quiet3 |-> ##0 s_start)
        else $error("Two-bit delay frame did not start on time");

    AST_SYNC_IGNORED: assert property (tx_active && fs_rise && fig && !frame_end
        |=> tx_active)
        else $error("Ignored frame sync disturbed the frame");

    AST_SYNC_RESTART: assert property (tx_active && fs_rise && !fig
        |=> q.state == stfc_pkg::ST_DELAY && q.word_cnt == 7'h00 && !q.phase2)
        else $error("Frame sync did not restart the transfer");

    AST_SINGLE_PHASE_END: assert property (word_end && !q.phase2 && !dual
        && q.word_cnt == len1 && !restart |=> q.state == stfc_pkg::ST_IDLE)
        else $error("Single-phase frame length wrong");

    AST_PHASE2_ENTRY: assert property (word_end && !q.phase2 && dual
        && q.word_cnt == len1 && !restart |=> q.phase2 && q.word_cnt == 7'h00 && tx_active)
        else $error("Second phase not entered");

    AST_PHASE2_END: assert property (word_end && q.phase2 && q.word_cnt == len2
        && !restart |=> q.state == stfc_pkg::ST_IDLE)
        else $error("Second phase length wrong");

    AST_PH2_BITS: assert property (load && load_ph2 && bits2 == stfc_pkg::WL_24
        |=> q.bit_cnt == 6'h17)
        else $error("Phase-two word length wrong");

    AST_PH1_BITS: assert property (load && !load_ph2 && bits1 == stfc_pkg::WL_12
        |=> q.bit_cnt == 6'h0B)
        else $error("Phase-one word length wrong");

    AST_MSB_FIRST: assert property (plain_load && !load_ph2 && bits1 == stfc_pkg::WL_32
        |=> q.shift == $past(tx_word) ##1 tx_data == $past(tx_word[30], 2))
        else $error("Word not sent most significant bit first");

    AST_REVERSED: assert property (load && tx_valid && rev && cmp == stfc_pkg::CMP_NONE
        |=> tx_data == $past(tx_word[0]) && q.shift[0] == $past(tx_word[31]))
        else $error("Reversed word order wrong");

    AST_LSB_BYTE: assert property (load && tx_valid && !load_ph2 && bits1 == stfc_pkg::WL_8
        && cmp == stfc_pkg::CMP_LSB |=> q.shift[31:24] == $past(low_byte_rev))
        else $error("Eight-bit word not sent LSB first");

    AST_MU_ZERO: assert property (load && tx_valid && tx_word == 32'h0000_0000
        && !load_ph2 && bits1 == stfc_pkg::WL_8 && cmp == stfc_pkg::CMP_MU
        |=> q.shift[31:24] == 8'hFF)
        else $error("Mu-law code of zero wrong");

    AST_COMPAND_GATED: assert property (load && tx_valid && !rev && !load_ph2
        && bits1 == stfc_pkg::WL_16 && cmp != stfc_pkg::CMP_NONE
        |=> q.shift[31:16] == $past(tx_word[15:0]))
        else $error("Companding applied to a wide word");

endmodule

// file: design/stfc_word_fmt.sv
// Transmit word formatter: orders, compands and left-justifies one word.
// Assumes the caller shifts bit 31 of the result out first.
`timescale 1ns/10ps
module stfc_word_fmt (
    input  wire logic [31:0] word,      // Raw word from the source
    input  wire logic [2:0]  bits_code, // Word length code of the phase
    input  wire logic [1:0]  compand,   // Companding selection
    input  wire logic        reverse,   // Full 32-bit reversal
    output logic      [31:0] shift_word, // Left-justified result
    output logic      [5:0]  last_bit    // Word length minus one
);

    localparam logic [15:0] MU_CLIP = 16'h1FDE;
    localparam logic [15:0] MU_BIAS = 16'h0021;
    localparam logic [15:0] A_CLIP  = 16'h0FFF;
    localparam logic [7:0]  A_XOR   = 8'h55;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Reserved codes fall back to 8 bits so the frame still advances
    function automatic logic [5:0] word_last(input logic [2:0] code);
        case (code)
            stfc_pkg::WL_8:  word_last = 6'h07;
            stfc_pkg::WL_12: word_last = 6'h0B;
            stfc_pkg::WL_16: word_last = 6'h0F;
            stfc_pkg::WL_20: word_last = 6'h13;
            stfc_pkg::WL_24: word_last = 6'h17;
            stfc_pkg::WL_32: word_last = 6'h1F;
            default:         word_last = 6'h07;
        endcase
    endfunction

    function automatic logic [15:0] magnitude(input logic [15:0] x);
        magnitude = x[15] ? (~x + 16'h0001) : x;
    endfunction

    function automatic logic [7:0] mu_law(input logic [15:0] x);
        logic [15:0] m;
        logic [2:0]  seg;
        m = magnitude(x) >> 2;
        if (m > MU_CLIP) begin
            m = MU_CLIP;
        end
        m = m + MU_BIAS;
        seg = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (m[i+5]) begin
                seg = i[2:0];
            end
        end
        mu_law = ~{x[15], seg, m[seg+1 +: 4]};
    endfunction

    function automatic logic [7:0] a_law(input logic [15:0] x);
        logic [15:0] m;
        logic [2:0]  seg;
        m = magnitude(x) >> 3;
        if (m > A_CLIP) begin
            m = A_CLIP;
        end
        seg = 3'h0;
        for (int i = 1; i < 8; i++) begin
            if (m[i+4]) begin
                seg = i[2:0];
            end
        end
        // Mantissa sits just below the segment's leading one
        a_law = {~x[15], seg, (seg == 3'h0) ? m[4:1] : m[seg +: 4]} ^ A_XOR;
    endfunction

    // ************************************************************
    // Bit-reversed copy
    // ************************************************************
    logic [31:0] rev_word;
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_rev
            assign rev_word[g] = word[31-g];
        end
    endgenerate

    // ************************************************************
    // Selection
    // ************************************************************
    always_comb begin
        last_bit = word_last(bits_code);
        // Companding only exists for 8-bit words; otherwise it is ignored
        if (bits_code == stfc_pkg::WL_8 && compand == stfc_pkg::CMP_MU) begin
            shift_word = {mu_law(word[15:0]), 24'h00_0000};
        end else if (bits_code == stfc_pkg::WL_8 && compand == stfc_pkg::CMP_A) begin
            shift_word = {a_law(word[15:0]), 24'h00_0000};
        end else if (bits_code == stfc_pkg::WL_8 && compand == stfc_pkg::CMP_LSB) begin
            shift_word = {rev_word[31:24], 24'h00_0000};
        end else if (reverse) begin
            shift_word = rev_word;
        end else begin
            shift_word = word << (6'h1F - last_bit);
        end
    end

endmodule

// file: tb/stfc_codec_model.sv
// Far-side codec model: issues frame sync and captures the serial stream.
// Assumes one data bit per core clock, qualified by tx_active.
`timescale 1ns/10ps
module stfc_codec_model (
    input  wire logic        clock,       // Core clock
    input  wire logic        fs_req,      // Bench asks for one sync pulse
    input  wire logic        clr,         // Clear capture state
    input  wire logic        tx_data,     // Serial data from the block
    input  wire logic        tx_active,   // Data bit qualifier
    output logic             tx_sync_pin, // Frame sync toward the block
    output logic      [63:0] cap_q,       // Captured bits, newest at bit 0
    output int               bits_q,      // Number of bits captured
    output int               lat_q        // Cycles from first sync to first bit
);
    logic [1:0] fs_cnt = 2'h0;
    logic       run_q  = 1'b0;

    // ****************************************
    // Sync pulse, two cycles, low between frames
    // ****************************************
    always @(posedge clock) begin
        if (fs_req)
            fs_cnt <= 2'h2;
        else if (fs_cnt != 2'h0)
            fs_cnt <= fs_cnt - 2'h1;
    end
    assign tx_sync_pin = (fs_cnt != 2'h0);

    // ****************************************
    // Capture
    // ****************************************
    always @(posedge clock) begin
        if (clr) begin
            cap_q  <= 64'h0000_0000_0000_0000;
            bits_q <= 0;
            lat_q  <= 0;
            run_q  <= 1'b0;
        end else begin
            if (fs_req)
                run_q <= 1'b1;
            if (run_q && bits_q == 0 && !tx_active)
                lat_q <= lat_q + 1;
            if (tx_active) begin
                cap_q  <= {cap_q[62:0], tx_data};
                bits_q <= bits_q + 1;
            end
        end
    end
endmodule

// file: tb/stfc_tx_frame_cfg_bench.sv
// Self-checking bench for the transmit frame configuration block.
// Assumes control at offset 0x0 and a codec model on the serial side.
`timescale 1ns/10ps
module stfc_tx_frame_cfg_bench;
    logic        clock     = 1'b0;
    logic        rstn      = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] tx_word   = 32'h8765_4321;
    logic        tx_valid  = 1'b1;
    logic        fs_req    = 1'b0;
    logic        clr       = 1'b0;
    logic [31:0] reg_rdata;
    logic        tx_sync_pin;
    logic        tx_ready;
    logic        tx_data;
    logic        tx_active;
    logic [63:0] cap;
    logic [31:0] rd;
    int          bits;
    int          lat;
    int          lat0;
    int          rdy_cnt    = 0;
    logic [63:0] lo;
    int          bad_count  = 0;
    int          num_checks = 0;
    int          cycles     = 0;
    int          wl[6]      = '{8, 12, 16, 20, 24, 32};

    always #2 clock = ~clock;

    stfc_tx_frame_cfg dut_u (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .tx_sync_pin, .tx_word, .tx_valid, .tx_ready, .tx_data, .tx_active);
    stfc_codec_model codec_u (.clock, .fs_req, .clr, .tx_data, .tx_active, .tx_sync_pin,
        .cap_q(cap), .bits_q(bits), .lat_q(lat));

    // ****************************************
    // Tasks
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata;
    endtask

    // Second sync after gap cycles when gap is nonzero; ends once the line idles
    task automatic frame(input logic [31:0] ctrl, input int gap);
        int idle;
        idle    = 0;
        rdy_cnt = 0;
        reg_write(4'h0, ctrl);
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr    <= 1'b0;
        fs_req <= 1'b1;
        @(posedge clock);
        fs_req <= 1'b0;
        if (gap > 0) begin
            repeat (gap) @(posedge clock);
            fs_req <= 1'b1;
            @(posedge clock);
            fs_req <= 1'b0;
        end
        for (int i = 0; i < 3000 && idle < 8; i++) begin
            @(posedge clock);
            idle = (bits > 0 && !tx_active) ? idle + 1 : 0;
        end
    endtask

    task automatic run(input logic [31:0] ctrl, input int gap, input int nb,
                       input logic [63:0] exp);
        logic [63:0] m;
        m = (64'h0000_0000_0000_0001 << nb) - 64'h0000_0000_0000_0001;
        frame(ctrl, gap);
        check("bit count", 64'(bits), 64'(nb));
        check("frame data", cap & m, exp & m);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (tx_ready)
            rdy_cnt++;
        if (cycles == 30000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        reg_read(4'h0, rd);
        check("control reset", 64'(rd), 64'h0);
        reg_write(4'h0, 32'hFFFF_FFFF);
        reg_read(4'h0, rd);
        check("control readback", 64'(rd), 64'hFFFF_7FF0);
        reg_read(4'h8, rd);
        check("unmapped read", 64'(rd), 64'h0);
        $display("test registers done");
        for (int c = 0; c < 6; c++) begin
            run(32'(c << 5), 0, wl[c], 64'h8765_4321);
            lo = 64'h8765_4321 & ~(64'hFFFF_FFFF_FFFF_FFFF << wl[c]);
            run(32'h8000_0000 | 32'(c << 21), 0, 8 + wl[c],
                (64'h21 << wl[c]) | lo);
        end
        $display("test word lengths done");
        run(32'h0000_0200, 0, 24, 64'h21_2121);
        run(32'h8300_0000, 0, 40, 64'h21_2121_2121);
        run(32'hFF00_7F00, 0, 2048, 64'h2121_2121_2121_2121);
        check("words taken", 64'(rdy_cnt), 64'h100);
        $display("test word counts done");
        tx_word <= 32'h0000_0001;
        run(32'h0008_0000, 0, 8, 64'h80);
        run(32'h0010_0040, 0, 16, 64'h0001);
        run(32'h0000_00B0, 0, 32, 64'h8000_0000);
        tx_word <= 32'h0000_0000;
        run(32'h0010_0000, 0, 8, 64'hFF);
        run(32'h0018_0000, 0, 8, 64'hD5);
        tx_word <= 32'h0000_1000;
        run(32'h0010_0000, 0, 8, 64'hAF);
        run(32'h0018_0000, 0, 8, 64'h85);
        $display("test bit order and companding done");
        tx_word <= 32'h8765_4321;
        for (int d = 0; d < 4; d++) begin
            run(32'(d << 16), 0, 8, 64'h21);
            if (d == 0)
                lat0 = lat;
            check("data delay", 64'(lat - lat0), 64'((d == 3) ? 2 : d));
        end
        $display("test data delay done");
        frame(32'h0000_0300, 10);
        check("restart on sync", 64'(bits > 32), 64'h1);
        run(32'h0004_0300, 10, 32, 64'h2121_2121);
        $display("test frame sync handling done");
        tx_valid <= 1'b0;
        run(32'h0000_0000, 0, 8, 64'h00);
        tx_valid <= 1'b1;
        reg_read(4'h4, rd);
        check("underrun flag", 64'(rd), 64'h200);
        reg_write(4'h4, 32'h0000_0200);
        reg_read(4'h4, rd);
        check("underrun clear", 64'(rd), 64'h0);
        $display("test underrun done");
        print_verdict();
    end
endmodule
